// [inc/dtmr_pkg.sv]
package dtmr_pkg;
	// Byte offsets of the registers, kept at their printed values
	localparam logic [19:0] OFS_CTRL_CH0   = 20'h0_fff80;
	localparam logic [19:0] OFS_CTRL_CH1   = 20'h0_fff81;
	localparam logic [19:0] OFS_STAT_CH0   = 20'h0_fff82;
	localparam logic [19:0] OFS_STAT_CH1   = 20'h0_fff83;
	localparam logic [19:0] OFS_CONST_A0   = 20'h0_fff84;
	localparam logic [19:0] OFS_CONST_A1   = 20'h0_fff85;
	localparam logic [19:0] OFS_CONST_B0   = 20'h0_fff86;
	localparam logic [19:0] OFS_CONST_B1   = 20'h0_fff87;
	localparam logic [19:0] OFS_COUNT_CH0  = 20'h0_fff88;
	localparam logic [19:0] OFS_COUNT_CH1  = 20'h0_fff89;
	localparam logic [19:0] OFS_CAPCFG     = 20'h0_fff8a;
	// Control register fields
	localparam int BIT_MATCH_B_IE  = 7;
	localparam int BIT_MATCH_A_IE  = 6;
	localparam int BIT_OVF_IE      = 5;
	localparam int BIT_CLR_HI      = 4;
	localparam int BIT_CLR_LO      = 3;
	localparam int BIT_CKS_HI      = 2;
	// Status register flag positions
	localparam int BIT_MATCH_B_FLG = 7;
	localparam int BIT_MATCH_A_FLG = 6;
	localparam int BIT_OVF_FLG     = 5;
	// Reset values, counter maximum and reserved status read bits
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam logic [7:0] CONST_RST   = 8'hff;
	localparam logic [7:0] COUNT_RST   = 8'h00;
	localparam logic [7:0] COUNT_MAX   = 8'hff;
	localparam logic [7:0] STAT_RD_RSV = 8'h1f;
	// Prescaler divide ratios and reset value
	localparam int DIV_A = 8;
	localparam int DIV_B = 64;
	localparam int DIV_C = 8192;
	localparam logic [12:0] PRESC_RST = 13'h0000;
	// Clock select codes
	localparam logic [2:0] CKS_OFF     = 3'h0;
	localparam logic [2:0] CKS_DIV_A   = 3'h1;
	localparam logic [2:0] CKS_DIV_B   = 3'h2;
	localparam logic [2:0] CKS_DIV_C   = 3'h3;
	localparam logic [2:0] CKS_CASCADE = 3'h4;
	localparam logic [2:0] CKS_EXT_FAL = 3'h5;
	localparam logic [2:0] CKS_EXT_RIS = 3'h6;
	localparam logic [2:0] CKS_EXT_BTH = 3'h7;
	// Counter clear codes
	localparam logic [1:0] CLR_NONE   = 2'h0;
	localparam logic [1:0] CLR_MATCHA = 2'h1;
	localparam logic [1:0] CLR_MATCHB = 2'h2;
	localparam logic [1:0] CLR_CAPB   = 2'h3;
	// Bus slave states
	typedef enum logic [0:0] {DTMR_IDLE, DTMR_ANSWER} dtmr_bus_e;
endpackage

// [rtl/dtmr_chan.sv]
`timescale 1ns/100ps
`default_nettype none
// One 8-bit channel: tick selection, counter, compares, flags
module dtmr_chan
	import dtmr_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	// Configuration
	input  wire logic [7:0] ctrl,
	input  wire logic [7:0] constant_a,
	input  wire logic [7:0] constant_b_cmp,
	input  wire logic       capture_mode,
	// Timebase events
	input  wire logic       tick_a,
	input  wire logic       tick_b,
	input  wire logic       tick_c,
	input  wire logic       cascade_evt,
	input  wire logic       ext_rise,
	input  wire logic       ext_fall,
	input  wire logic       capture_evt,
	// Software access
	input  wire logic       cnt_wr,
	input  wire logic [7:0] cnt_wdata,
	input  wire logic       flag_rd,
	input  wire logic       flag_wr,
	input  wire logic [2:0] flag_wdata,
	// Results
	output logic      [7:0] count_value,
	output logic      [2:0] flags,
	output logic            match_a_evt,
	output logic            overflow_evt
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [2:0] flg;
		logic [2:0] armed;
	} dtmr_chan_s;

	dtmr_chan_s st_ff;
	dtmr_chan_s nxt_st;
	logic       tick;
	logic       match_b_evt;
	logic       clr;
	logic [2:0] setv;

	// Source picker; cascade deadlock is left to software
	always_comb begin
		case (ctrl[BIT_CKS_HI:0])
			CKS_DIV_A:   tick = tick_a;
			CKS_DIV_B:   tick = tick_b;
			CKS_DIV_C:   tick = tick_c;
			CKS_CASCADE: tick = cascade_evt;
			CKS_EXT_FAL: tick = ext_fall;
			CKS_EXT_RIS: tick = ext_rise;
			CKS_EXT_BTH: tick = ext_fall | ext_rise;
			default:     tick = 1'b0;
		endcase
	end

	// Matches are seen on the counter as it stands this cycle
	assign match_a_evt  = tick && st_ff.cnt == constant_a;
	assign match_b_evt  = capture_mode ? capture_evt
		: (tick && st_ff.cnt == constant_b_cmp);
	assign overflow_evt = tick && st_ff.cnt == COUNT_MAX;
	assign setv = {match_b_evt, match_a_evt, overflow_evt};

	// Clear selection
	always_comb begin
		case (ctrl[BIT_CLR_HI:BIT_CLR_LO])
			CLR_MATCHA: clr = match_a_evt;
			CLR_MATCHB: clr = match_b_evt;
			CLR_CAPB:   clr = capture_mode && capture_evt;
			default:    clr = 1'b0;
		endcase
	end

	// Counter and flags; a set in the same cycle beats a clear
	always_comb begin
		nxt_st = st_ff;
		if (cnt_wr) begin
			nxt_st.cnt = cnt_wdata;
		end else if (clr) begin
			nxt_st.cnt = COUNT_RST;
		end else if (tick) begin
			nxt_st.cnt = st_ff.cnt + 8'h01;
		end
		if (flag_rd) begin
			nxt_st.armed = st_ff.flg;
		end
		if (flag_wr) begin
			// Only a zero on an armed flag clears; ones are ignored
			nxt_st.flg = st_ff.flg & ~(st_ff.armed & ~flag_wdata);
			nxt_st.armed = st_ff.armed & flag_wdata;
		end
		nxt_st.flg = nxt_st.flg | setv;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign count_value = st_ff.cnt;
	assign flags       = st_ff.flg;
endmodule
`default_nettype wire

// [rtl/dtmr_top.sv]
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Clock select 0 stops counting; 1..3 count at clock/8, /64, /8192
// - Cascade: ch0 counts ch1 overflows, ch1 counts ch0 match A
// - External codes count falling, rising or both edges of ext clock
// - Clear select: none, match A, match B or capture B, capture B only
// - Overflow enable gates overflow flag onto overflow interrupt
// - Match A enable gates match A flag onto its interrupt
// - Match B enable gates match B flag onto its interrupt
// - Match B flag sets on counter equal B, or on capture
// - Flag clears only after read as one then write of zero
// - Status flag bits accept only zero writes; ones never set them
// - Control layout: IE B 7, IE A 6, OVF IE 5, clear 4:3, clock 2:0
// - Overflow flag sets when counter rolls from all ones to zero
module dtmr_top
	import dtmr_pkg::*;
#(
	parameter int PRESC_W = 13
)
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Avalon-MM slave
	input  wire logic [19:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [7:0]  avs_writedata,
	output logic      [7:0]  avs_readdata,
	output logic             avs_waitrequest,
	// Timer pins
	input  wire logic        ext_clk,
	input  wire logic [1:0]  capture_in,
	// Interrupt requests, one per channel
	output logic      [1:0]  overflow_irq,
	output logic      [1:0]  match_a_irq,
	output logic      [1:0]  match_b_irq
);
	typedef struct packed {
		dtmr_bus_e            bus;
		logic [7:0]           rdata;
		logic [1:0][7:0]      ctrl;
		logic [1:0][7:0]      const_a;
		logic [1:0][7:0]      const_b;
		logic [1:0]           cap_mode;
		logic [PRESC_W-1:0]   presc;
		logic                 ext_d;
		logic [1:0]           cap_d;
	} dtmr_top_s;

	dtmr_top_s          st_ff;
	dtmr_top_s          nxt_st;
	logic [PRESC_W-1:0] presc_inc;
	logic               tick_a;
	logic               tick_b;
	logic               tick_c;
	logic               ext_rise;
	logic               ext_fall;
	logic [1:0]         cap_evt;
	logic [1:0]         cap_load;
	logic [1:0]         cnt_wr;
	logic [1:0]         flag_rd;
	logic [1:0]         flag_wr;
	logic [1:0][7:0]    count_value;
	logic [1:0][2:0]    flags;
	logic [1:0]         match_a_evt;
	logic [1:0]         overflow_evt;
	logic [1:0]         cascade_evt;
	logic               acc_wr;
	logic               acc_rd;

	// Free-running prescaler; ticks mark the cycle before wrap of each tap
	assign presc_inc = st_ff.presc + PRESC_W'(1);
	assign tick_a    = presc_inc[$clog2(DIV_A)-1:0] == '0;
	assign tick_b    = presc_inc[$clog2(DIV_B)-1:0] == '0;
	assign tick_c    = presc_inc[$clog2(DIV_C)-1:0] == '0;

	// Pins are synchronous to sys_clk, so one stage is enough for edges
	assign ext_rise = ext_clk & ~st_ff.ext_d;
	assign ext_fall = ~ext_clk & st_ff.ext_d;
	assign cap_evt  = capture_in & ~st_ff.cap_d;

	// Cascade wiring between the two channels
	assign cascade_evt[0] = overflow_evt[1];
	assign cascade_evt[1] = match_a_evt[0];

	// Single-cycle answer: request taken while waitrequest is low
	assign acc_wr = avs_write && st_ff.bus == DTMR_ANSWER;
	assign acc_rd = avs_read && st_ff.bus == DTMR_ANSWER;
	assign avs_waitrequest = (avs_read | avs_write)
		&& st_ff.bus == DTMR_IDLE;
	assign avs_readdata = st_ff.rdata;

	// Per-channel strobes and interrupt gating
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			assign cnt_wr[gi]  = acc_wr &&
				avs_address == OFS_COUNT_CH0 + 20'(gi);
			assign flag_rd[gi] = acc_rd &&
				avs_address == OFS_STAT_CH0 + 20'(gi);
			assign flag_wr[gi] = acc_wr &&
				avs_address == OFS_STAT_CH0 + 20'(gi);
			assign cap_load[gi] = st_ff.cap_mode[gi] && cap_evt[gi];
			assign overflow_irq[gi] = flags[gi][2-BIT_MATCH_B_FLG+BIT_OVF_FLG]
				& st_ff.ctrl[gi][BIT_OVF_IE];
			assign match_a_irq[gi] = flags[gi][1]
				& st_ff.ctrl[gi][BIT_MATCH_A_IE];
			assign match_b_irq[gi] = flags[gi][2]
				& st_ff.ctrl[gi][BIT_MATCH_B_IE];

			dtmr_chan u_chan (
				.sys_clk        (sys_clk),
				.rst_b          (rst_b),
				.ctrl           (st_ff.ctrl[gi]),
				.constant_a     (st_ff.const_a[gi]),
				.constant_b_cmp (st_ff.const_b[gi]),
				.capture_mode   (st_ff.cap_mode[gi]),
				.tick_a         (tick_a),
				.tick_b         (tick_b),
				.tick_c         (tick_c),
				.cascade_evt    (cascade_evt[gi]),
				.ext_rise       (ext_rise),
				.ext_fall       (ext_fall),
				.capture_evt    (cap_evt[gi]),
				.cnt_wr         (cnt_wr[gi]),
				.cnt_wdata      (avs_writedata),
				.flag_rd        (flag_rd[gi]),
				.flag_wr        (flag_wr[gi]),
				.flag_wdata     (avs_writedata[BIT_MATCH_B_FLG:BIT_OVF_FLG]),
				.count_value    (count_value[gi]),
				.flags          (flags[gi]),
				.match_a_evt    (match_a_evt[gi]),
				.overflow_evt   (overflow_evt[gi])
			);
		end
	endgenerate

	// Register file, bus sequencing and capture loading
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.presc = presc_inc;
		nxt_st.ext_d = ext_clk;
		nxt_st.cap_d = capture_in;
		nxt_st.bus   = (st_ff.bus == DTMR_IDLE && (avs_read | avs_write))
			? DTMR_ANSWER : DTMR_IDLE;
		for (int i = 0; i < 2; i++) begin
			if (cap_load[i]) begin
				nxt_st.const_b[i] = count_value[i];
			end
		end
		if (acc_wr) begin
			if (avs_address == OFS_CTRL_CH0) begin
				nxt_st.ctrl[0] = avs_writedata;
			end else if (avs_address == OFS_CTRL_CH1) begin
				nxt_st.ctrl[1] = avs_writedata;
			end else if (avs_address == OFS_CONST_A0) begin
				nxt_st.const_a[0] = avs_writedata;
			end else if (avs_address == OFS_CONST_A1) begin
				nxt_st.const_a[1] = avs_writedata;
			end else if (avs_address == OFS_CONST_B0 && !cap_load[0]) begin
				nxt_st.const_b[0] = avs_writedata;
			end else if (avs_address == OFS_CONST_B1 && !cap_load[1]) begin
				nxt_st.const_b[1] = avs_writedata;
			end else if (avs_address == OFS_CAPCFG) begin
				nxt_st.cap_mode = avs_writedata[1:0];
			end
		end
		// Read data is captured in the request cycle, shown at the answer
		nxt_st.rdata = 8'h00;
		if (avs_read && st_ff.bus == DTMR_IDLE) begin
			if (avs_address == OFS_CTRL_CH0) begin
				nxt_st.rdata = st_ff.ctrl[0];
			end else if (avs_address == OFS_CTRL_CH1) begin
				nxt_st.rdata = st_ff.ctrl[1];
			end else if (avs_address == OFS_STAT_CH0) begin
				nxt_st.rdata = {flags[0], STAT_RD_RSV[4:0]};
			end else if (avs_address == OFS_STAT_CH1) begin
				nxt_st.rdata = {flags[1], STAT_RD_RSV[4:0]};
			end else if (avs_address == OFS_CONST_A0) begin
				nxt_st.rdata = st_ff.const_a[0];
			end else if (avs_address == OFS_CONST_A1) begin
				nxt_st.rdata = st_ff.const_a[1];
			end else if (avs_address == OFS_CONST_B0) begin
				nxt_st.rdata = st_ff.const_b[0];
			end else if (avs_address == OFS_CONST_B1) begin
				nxt_st.rdata = st_ff.const_b[1];
			end else if (avs_address == OFS_COUNT_CH0) begin
				nxt_st.rdata = count_value[0];
			end else if (avs_address == OFS_COUNT_CH1) begin
				nxt_st.rdata = count_value[1];
			end else if (avs_address == OFS_CAPCFG) begin
				nxt_st.rdata = {6'h00, st_ff.cap_mode};
			end
		end
	end

	// All control is cleared by reset; constants come back all ones
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st_ff          <= '0;
			st_ff.bus      <= DTMR_IDLE;
			st_ff.ctrl     <= {CTRL_RST, CTRL_RST};
			st_ff.const_a  <= {CONST_RST, CONST_RST};
			st_ff.const_b  <= {CONST_RST, CONST_RST};
			st_ff.presc    <= PRESC_W'(PRESC_RST);
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

// [verif/dtmr_props.sv]
`timescale 1ns/100ps
`default_nettype none
// Bus timing and interrupt output checks for the timer block
module dtmr_props
	import dtmr_pkg::*;
#(
	parameter int PRESC_W = 13
)
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// Bus
	input wire logic [19:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [7:0]  avs_writedata,
	input wire logic [7:0]  avs_readdata,
	input wire logic        avs_waitrequest,
	// Pins and requests
	input wire logic        ext_clk,
	input wire logic [1:0]  capture_in,
	input wire logic [1:0]  overflow_irq,
	input wire logic [1:0]  match_a_irq,
	input wire logic [1:0]  match_b_irq
);
	logic req;
	logic wr_tk;
	logic c0_wr;
	// Request present, write taken, control write of channel 0
	assign req = avs_read | avs_write;
	assign wr_tk = avs_write & ~avs_waitrequest;
	assign c0_wr = wr_tk & (avs_address == OFS_CTRL_CH0);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_WAIT_FIRST: assert property (req && !$past(req) |-> avs_waitrequest)
		else $error("no wait in first request cycle");
	AST_WAIT_ANSWER: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer not one cycle after request");
	AST_RD_IDLE: assert property (!(avs_read && !avs_waitrequest) |-> avs_readdata == 8'h00)
		else $error("read data outside answer cycle");
	AST_RD_UNMAP: assert property (avs_read && !avs_waitrequest && avs_address == 20'h0_fff9f
		|-> avs_readdata == 8'h00)
		else $error("unmapped read not zero");
	AST_OVF_GATE: assert property (c0_wr && !avs_writedata[BIT_OVF_IE] |-> ##2 !overflow_irq[0])
		else $error("overflow request not blocked");
	AST_MA_GATE: assert property (c0_wr && !avs_writedata[BIT_MATCH_A_IE] |-> ##2 !match_a_irq[0])
		else $error("match A request not blocked");
	AST_MB_GATE: assert property (c0_wr && !avs_writedata[BIT_MATCH_B_IE] |-> ##2 !match_b_irq[0])
		else $error("match B request not blocked");
	AST_MB_CLEAR: assert property ($fell(match_b_irq[0]) |-> $past(wr_tk, 1) || $past(wr_tk, 2))
		else $error("match B request dropped without a write");
	AST_IRQ_RESET: assert property ($rose(rst_b) |-> (overflow_irq | match_a_irq | match_b_irq) == 2'b00)
		else $error("interrupt request active after reset");
endmodule
bind dtmr_top dtmr_props #(.PRESC_W(PRESC_W)) u_dtmr_props (.sys_clk(sys_clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .ext_clk(ext_clk), .capture_in(capture_in),
	.overflow_irq(overflow_irq), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
`default_nettype wire

// [verif/test_dual_eight_bit_timer_control.sv]
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench driving the register bus and the external clock pin
module test_dual_eight_bit_timer_control
	import dtmr_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [19:0] adr = 20'h0_0000;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [7:0]  wd = 8'h00;
	logic [7:0]  rdat;
	logic        wreq;
	logic        ext_clk = 1'b0;
	logic [1:0]  cap = 2'b00;
	logic [1:0]  ovf;
	logic [1:0]  mta;
	logic [1:0]  mtb;
	logic [7:0]  q;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	// Device under test; capture pin 0 is pulsed by the capture scenario
	dtmr_top u_dtmr_top (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .ext_clk(ext_clk), .capture_in(cap),
		.overflow_irq(ovf), .match_a_irq(mta), .match_b_irq(mtb));
	// Clock and hang guard
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fail_count++;
			test_done();
		end
	end
	// Verdict
	task automatic test_done;
		if (fail_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One bus cycle; held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [19:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do @(posedge sys_clk); while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// The write lands at the answer edge; let it settle before any compare
	task automatic wrr(input logic [19:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
		@(posedge sys_clk);
	endtask
	task automatic rdc(input logic [19:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	// External clock pulses, slow enough for the one-stage edge detector
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge sys_clk) ext_clk <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ext_clk <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic t_regs;
		rdc(OFS_CTRL_CH0, 8'h00);
		rdc(OFS_STAT_CH0, STAT_RD_RSV);
		rdc(OFS_CONST_A0, 8'hff);
		rdc(20'h0_fff9f, 8'h00);
		wrr(OFS_CTRL_CH1, 8'hf8);
		rdc(OFS_CTRL_CH1, 8'hf8);
		wrr(OFS_CTRL_CH1, 8'h00);
		wrr(OFS_STAT_CH0, 8'hff);
		rdc(OFS_STAT_CH0, STAT_RD_RSV);
	endtask
	task automatic t_presc;
		int d;
		for (int i = 1; i < 4; i++) begin
			d = (i == 1) ? DIV_A : (i == 2) ? DIV_B : DIV_C;
			wrr(OFS_COUNT_CH0, 8'h00);
			wrr(OFS_CTRL_CH0, 8'(i));
			repeat (4 * d) @(posedge sys_clk);
			wrr(OFS_CTRL_CH0, 8'h00);
			bus(1'b0, OFS_COUNT_CH0, 8'h00);
			chk({7'h00, q == 8'h04 || q == 8'h05}, 8'h01);
			repeat (100) @(posedge sys_clk);
			rdc(OFS_COUNT_CH0, q);
		end
	endtask
	task automatic t_ext;
		for (int c = 5; c < 8; c++) begin
			wrr(OFS_COUNT_CH0, 8'h00);
			wrr(OFS_CTRL_CH0, 8'(c));
			pulses(4);
			wrr(OFS_CTRL_CH0, 8'h00);
			rdc(OFS_COUNT_CH0, (c == 7) ? 8'h08 : 8'h04);
		end
	endtask
	task automatic t_ovf;
		wrr(OFS_CONST_A0, 8'h10);
		wrr(OFS_CONST_B0, 8'h20);
		wrr(OFS_COUNT_CH0, 8'hfe);
		wrr(OFS_CTRL_CH0, 8'h26);
		pulses(1);
		chk({7'h00, ovf[0]}, 8'h00);
		pulses(1);
		chk({7'h00, ovf[0]}, 8'h01);
		rdc(OFS_COUNT_CH0, 8'h00);
		wrr(OFS_STAT_CH0, 8'h00);
		chk({7'h00, ovf[0]}, 8'h01);
		rdc(OFS_STAT_CH0, 8'h3f);
		wrr(OFS_STAT_CH0, 8'hdf);
		chk({7'h00, ovf[0]}, 8'h00);
	endtask
	task automatic t_match;
		wrr(OFS_CONST_A0, 8'h03);
		wrr(OFS_CTRL_CH0, 8'h4e);
		pulses(4);
		chk({7'h00, mta[0]}, 8'h01);
		rdc(OFS_COUNT_CH0, 8'h00);
		wrr(OFS_CTRL_CH0, 8'h0e);
		chk({7'h00, mta[0]}, 8'h00);
		rdc(OFS_STAT_CH0, 8'h5f);
		wrr(OFS_STAT_CH0, 8'h00);
		wrr(OFS_CONST_B0, 8'h02);
		wrr(OFS_CTRL_CH0, 8'h96);
		pulses(3);
		chk({7'h00, mtb[0]}, 8'h01);
		rdc(OFS_COUNT_CH0, 8'h00);
		rdc(OFS_STAT_CH0, 8'h9f);
		wrr(OFS_STAT_CH0, 8'h7f);
		chk({7'h00, mtb[0]}, 8'h00);
	endtask
	// Cascade both ways, one direction at a time; never both at once
	task automatic t_casc;
		wrr(OFS_CONST_A0, 8'h01);
		wrr(OFS_CTRL_CH0, 8'h0e);
		wrr(OFS_CTRL_CH1, 8'h04);
		pulses(4);
		rdc(OFS_COUNT_CH1, 8'h02);
		wrr(OFS_CTRL_CH1, 8'h06);
		wrr(OFS_COUNT_CH0, 8'h00);
		wrr(OFS_COUNT_CH1, 8'hfe);
		wrr(OFS_CTRL_CH0, 8'h04);
		pulses(2);
		rdc(OFS_COUNT_CH0, 8'h01);
	endtask
	// Capture on channel 0 loads constant B, sets its flag, clears counter
	task automatic t_cap;
		wrr(OFS_CTRL_CH1, 8'h00);
		wrr(OFS_CAPCFG, 8'h01);
		wrr(OFS_COUNT_CH0, 8'h00);
		wrr(OFS_CTRL_CH0, 8'h9e);
		pulses(3);
		@(posedge sys_clk) cap <= 2'b01;
		@(posedge sys_clk) cap <= 2'b00;
		repeat (2) @(posedge sys_clk);
		chk({7'h00, mtb[0]}, 8'h01);
		rdc(OFS_CONST_B0, 8'h03);
		rdc(OFS_COUNT_CH0, 8'h00);
		rdc(OFS_STAT_CH0, 8'hdf);
		wrr(OFS_STAT_CH0, 8'h3f);
		chk({7'h00, mtb[0]}, 8'h00);
		wrr(OFS_CTRL_CH0, 8'h00);
		wrr(OFS_CAPCFG, 8'h00);
	endtask
	// Mid-run reset with the overflow request raised; requests, ch1 control and count, constant A0 must return to reset state
	task automatic t_rst;
		wrr(OFS_COUNT_CH1, 8'h55);
		wrr(OFS_CTRL_CH1, 8'h20);
		chk({7'h00, ovf[1]}, 8'h01);
		@(posedge sys_clk) rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		chk({6'h00, ovf | mta | mtb}, 8'h00);
		rdc(OFS_CTRL_CH1, 8'h00);
		rdc(OFS_COUNT_CH1, 8'h00);
		rdc(OFS_CONST_A0, 8'hff);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		t_presc();
		t_ext();
		t_ovf();
		t_match();
		t_casc();
		t_cap();
		t_rst();
		test_done();
	end
endmodule
`default_nettype wire
